// file: pipe_sched_model.sv
// pipeline and scheduler model raising per-thread event pulses
`timescale 1ns/1ns
module pipe_sched_model #(
  parameter int N = 4
) (
  input wire logic i_clk,
  output logic [N-1:0] o_retire,
  output logic [N-1:0] o_halt,
  output logic [N-1:0] o_restart_wr,
  output logic [N-1:0] o_thread_release_instr_dealloc,
  output logic [N-1:0] o_halt_in_ds,
  output logic [2*N-1:0] o_run_state
);
  logic [N-1:0] ev [4];
  assign o_retire = ev[0];
  assign o_halt = ev[1];
  assign o_restart_wr = ev[2];
  assign o_thread_release_instr_dealloc = ev[3];
  initial begin
    foreach (ev[k]) ev[k] = '0;
    o_halt_in_ds = '0;
    o_run_state = '0;
  end
  // one cycle only, so a single event is never counted twice
  task automatic pulse(input int k, input int t, input logic ds);
    @(negedge i_clk);
    ev[k][t] = 1'b1;
    o_halt_in_ds[t] = ds;
    @(negedge i_clk);
    ev[k] = '0;
  endtask : pulse
  // changed only while nobody reads, as software trusts a settled value
  task automatic set_rs(input int t, input logic [1:0] v);
    o_run_state[2*t +: 2] = v;
  endtask : set_rs
endmodule : pipe_sched_model

// file: test_thread_context_status_bank.sv
// self-checking bench for the thread context status bank
`timescale 1ns/1ns
module test_thread_context_status_bank;
  logic clk, rst, wr, rd, st_wr, eh_wr, fgo, media, fok, ce;
  logic [1:0] wtc, rtc, cur, fsrc, fdst, priv, o_priv;
  logic [2:0] inh;
  logic [3:0] cu, o_cu, retire, halt, ds, rsw, yld, ixm, fpr;
  logic [7:0] asid, o_asid, rs;
  logic [31:0] wdata, rdata;
  int failures, n_checks;
  thread_context_status_bank #(.NUM_THREADS(4), .HAS_TLB(1'b1)) dut (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_sw_wr(wr), .i_sw_tc(wtc),
    .i_sw_wdata(wdata), .i_sw_rd(rd), .i_sw_rd_tc(rtc), .o_rd_data(rdata),
    .o_rd_valid(), .i_cur_tc(cur), .i_status_wr(st_wr),
    .i_status_coproc_usable_bits(cu), .i_status_media_enable_bit(media),
    .i_status_privilege_field(priv), .i_entry_high_wr(eh_wr),
    .i_entry_high_asid(asid), .o_status_coproc_usable_bits(o_cu),
    .o_status_media_enable_bit(), .o_status_privilege_field(o_priv),
    .o_entry_high_asid(o_asid), .i_retire(retire),
    .i_exception_level_bit(inh[0]), .i_error_level_bit(inh[1]),
    .i_debug_mode(inh[2]), .i_halt(halt), .i_halt_in_ds(ds),
    .i_restart_wr(rsw), .i_run_state(rs), .i_fork(fgo), .i_fork_src(fsrc),
    .i_fork_dst(fdst), .o_fork_ok(fok), .i_thread_release_instr_dealloc(yld),
    .o_dyn_alloc_en(), .o_activated(), .o_intr_exempt(ixm), .o_fpr_mode(fpr),
    .o_media_en(), .o_dirty());
  pipe_sched_model #(.N(4)) pm (.i_clk(clk), .o_retire(retire),
    .o_halt(halt), .o_restart_wr(rsw), .o_thread_release_instr_dealloc(yld),
    .o_halt_in_ds(ds), .o_run_state(rs));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrc(input logic [1:0] t, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    wtc = t;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wrc
  task automatic rdc(input logic [1:0] t, input logic [31:0] exp);
    @(negedge clk);
    rd = 1'b1;
    rtc = t;
    @(negedge clk);
    rd = 1'b0;
    chk(rdata, exp);
  endtask : rdc
  task automatic fk(input logic e);
    @(negedge clk);
    fgo = 1'b1;
    fsrc = 2'h1;
    fdst = 2'h3;
    #1 chk(fok, e);
    @(negedge clk);
    fgo = 1'b0;
  endtask : fk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    failures++;
    tally_and_finish();
  end
  initial begin
    {rst, wr, rd, st_wr, eh_wr, fgo, media, ce} = 8'h81;
    {wtc, rtc, cur, fsrc, fdst, priv, inh, cu, asid, wdata} = '0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rdc(2'h0, 32'h0000_2000);
    for (int t = 1; t < 4; t++) rdc(t[1:0], 32'h0);
    $display("test reset done");
    wrc(2'h1, 32'hffff_ffff);
    rdc(2'h1, 32'hfc10_bcff);
    chk(ixm, 32'h2);
    chk(fpr, 32'h2);
    cur = 2'h1;
    #1 chk(o_cu, 32'hf);
    chk(o_priv, 32'h3);
    chk(o_asid, 32'hff);
    @(negedge clk);
    cur = 2'h2;
    {cu, media, priv, asid, st_wr, eh_wr} = {4'h5, 1'b1, 2'h2, 8'h3c, 2'h3};
    @(negedge clk);
    {st_wr, eh_wr} = 2'h0;
    rdc(2'h2, 32'h5800_103c);
    $display("test access done");
    for (int k = 0; k < 3; k++) begin
      inh = 3'h1 << k;
      pm.pulse(0, 2, 1'b0);
      rdc(2'h2, 32'h5800_103c);
    end
    inh = 3'h0;
    pm.pulse(0, 2, 1'b0);
    rdc(2'h2, 32'h5810_103c);
    wrc(2'h2, 32'h0);
    rdc(2'h2, 32'h0);
    // a frozen clock enable must swallow the whole write
    ce = 1'b0;
    wrc(2'h2, 32'hffff_ffff);
    ce = 1'b1;
    rdc(2'h2, 32'h0);
    for (int v = 0; v < 4; v++) begin
      pm.set_rs(3, v[1:0]);
      rdc(2'h3, 32'(v) << 23);
    end
    pm.set_rs(3, 2'h0);
    $display("test events done");
    fk(1'b0);
    rdc(2'h3, 32'h0);
    wrc(2'h3, 32'h0000_8000);
    fk(1'b1);
    rdc(2'h3, 32'h0410_b8ff);
    chk(fpr, 32'ha);
    chk(ixm, 32'h2);
    pm.pulse(3, 3, 1'b0);
    rdc(2'h3, 32'h0410_98ff);
    pm.pulse(1, 1, 1'b1);
    rdc(2'h1, 32'hfc30_bcff);
    pm.pulse(2, 1, 1'b0);
    rdc(2'h1, 32'hfc10_bcff);
    pm.pulse(1, 1, 1'b1);
    pm.pulse(1, 1, 1'b0);
    rdc(2'h1, 32'hfc10_bcff);
    $display("test fork and halt done");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rdc(2'h1, 32'h0);
    rdc(2'h0, 32'h0000_2000);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : test_thread_context_status_bank

// file: thread_context_status_bank.sv
// per-thread context status registers with shared-register mirrors
`timescale 1ns/1ns
`include "thread_context_status_defines.svh"

module thread_context_status_bank #(
  parameter int NUM_THREADS = 4,
  parameter bit HAS_TLB = 1'b1,
  localparam int TW = (NUM_THREADS > 1) ? $clog2(NUM_THREADS) : 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // system-coprocessor move into a thread's status word
  input wire logic i_sw_wr,
  input wire logic [TW-1:0] i_sw_tc,
  input wire logic [31:0] i_sw_wdata,
  // system-coprocessor or cross-thread read
  input wire logic i_sw_rd,
  input wire logic [TW-1:0] i_sw_rd_tc,
  output logic [31:0] o_rd_data,
  output logic o_rd_valid,
  // thread that references the shared status and entry-high registers
  input wire logic [TW-1:0] i_cur_tc,
  input wire logic i_status_wr,
  input wire logic [3:0] i_status_coproc_usable_bits,
  input wire logic i_status_media_enable_bit,
  input wire logic [1:0] i_status_privilege_field,
  input wire logic i_entry_high_wr,
  input wire logic [7:0] i_entry_high_asid,
  output logic [3:0] o_status_coproc_usable_bits,
  output logic o_status_media_enable_bit,
  output logic [1:0] o_status_privilege_field,
  output logic [7:0] o_entry_high_asid,
  // pipeline events
  input wire logic [NUM_THREADS-1:0] i_retire,
  input wire logic i_exception_level_bit,
  input wire logic i_error_level_bit,
  input wire logic i_debug_mode,
  input wire logic [NUM_THREADS-1:0] i_halt,
  input wire logic [NUM_THREADS-1:0] i_halt_in_ds,
  input wire logic [NUM_THREADS-1:0] i_restart_wr,
  input wire logic [2*NUM_THREADS-1:0] i_run_state,
  // scheduler: allocation and release
  input wire logic i_fork,
  input wire logic [TW-1:0] i_fork_src,
  input wire logic [TW-1:0] i_fork_dst,
  output logic o_fork_ok,
  input wire logic [NUM_THREADS-1:0] i_thread_release_instr_dealloc,
  // per-thread control levels
  output logic [NUM_THREADS-1:0] o_dyn_alloc_en,
  output logic [NUM_THREADS-1:0] o_activated,
  output logic [NUM_THREADS-1:0] o_intr_exempt,
  output logic [NUM_THREADS-1:0] o_fpr_mode,
  output logic [NUM_THREADS-1:0] o_media_en,
  output logic [NUM_THREADS-1:0] o_dirty
);

  typedef struct packed {
    thread_context_status_pkg::ctx_fields_t [NUM_THREADS-1:0] ctx;
    logic [31:0] rd_data;
    logic rd_valid;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [NUM_THREADS-1:0][31:0] words;
  logic fork_go;

  // decode of a written word; used for the direct move only
  function automatic thread_context_status_pkg::ctx_fields_t unpack_word(
    input thread_context_status_pkg::ctx_fields_t old,
    input logic [31:0] w
  );
    thread_context_status_pkg::ctx_fields_t f;
    f = old;
    f.thread_coproc_usable = w[`TCS_COPROC_HI:`TCS_COPROC_LO];
    f.thread_media_enable = w[`TCS_MEDIA_BIT];
    f.thread_fpr_mode = w[`TCS_FR_BIT];
    f.dirty_flag = w[`TCS_DIRTY_BIT];
    f.dynamic_alloc_enable = w[`TCS_ALLOC_BIT];
    f.activated = w[`TCS_ACT_BIT];
    f.thread_privilege_mode = w[`TCS_PRIV_HI:`TCS_PRIV_LO];
    f.interrupt_exempt = w[`TCS_EXEMPT_BIT];
    if (HAS_TLB) begin
      f.thread_space_id = w[`TCS_ASID_HI:`TCS_ASID_LO];
    end
    return f;
  endfunction : unpack_word

  // one packed view per thread context
  for (genvar g = 0; g < NUM_THREADS; g++) begin : g_word
    thread_status_word #(
      .HAS_TLB(HAS_TLB)
    ) u_word (
      .i_fields(state_q.ctx[g]),
      .o_word(words[g])
    );
    assign o_dyn_alloc_en[g] = state_q.ctx[g].dynamic_alloc_enable;
    assign o_activated[g] = state_q.ctx[g].activated;
    assign o_intr_exempt[g] = state_q.ctx[g].interrupt_exempt;
    assign o_fpr_mode[g] = state_q.ctx[g].thread_fpr_mode;
    assign o_media_en[g] = state_q.ctx[g].thread_media_enable;
    assign o_dirty[g] = state_q.ctx[g].dirty_flag;
  end

  // fork is refused unless the target allows dynamic allocation
  assign fork_go = i_fork && state_q.ctx[i_fork_dst].dynamic_alloc_enable;
  assign o_fork_ok = fork_go;

  // shared-register views of the referencing thread
  assign o_status_coproc_usable_bits =
    state_q.ctx[i_cur_tc].thread_coproc_usable;
  assign o_status_media_enable_bit = state_q.ctx[i_cur_tc].thread_media_enable;
  assign o_status_privilege_field =
    state_q.ctx[i_cur_tc].thread_privilege_mode;
  assign o_entry_high_asid = HAS_TLB ? state_q.ctx[i_cur_tc].thread_space_id
                                     : 8'h00;

  assign o_rd_data = state_q.rd_data;
  assign o_rd_valid = state_q.rd_valid;

  always_comb begin
    thread_context_status_pkg::ctx_fields_t f;
    thread_context_status_pkg::ctx_fields_t src;
    logic retire_counts;
    state_d = state_q;
    f = state_q.ctx[0];
    src = state_q.ctx[i_fork_src];
    // exception, error level or debug keeps retirement from dirtying
    retire_counts = !(i_exception_level_bit || i_error_level_bit ||
                      i_debug_mode);
    for (int t = 0; t < NUM_THREADS; t++) begin
      f = state_q.ctx[t];
      // software move first, so hardware events below take priority
      if (i_sw_wr && i_sw_tc == TW'(t)) begin
        f = unpack_word(f, i_sw_wdata);
      end
      // writes through the shared registers land in the same bits
      if (i_status_wr && i_cur_tc == TW'(t)) begin
        f.thread_coproc_usable = i_status_coproc_usable_bits;
        f.thread_media_enable = i_status_media_enable_bit;
        f.thread_privilege_mode = i_status_privilege_field;
      end
      if (HAS_TLB && i_entry_high_wr && i_cur_tc == TW'(t)) begin
        f.thread_space_id = i_entry_high_asid;
      end
      // run state is owned by the scheduler, software cannot write it
      f.run_state = thread_context_status_pkg::run_state_t'(
        i_run_state[2*t +: 2]);
      // restart write clears, a halt in the same cycle wins
      if (i_restart_wr[t]) begin
        f.halted_in_delay_slot = 1'b0;
      end
      if (i_halt[t]) begin
        f.halted_in_delay_slot = i_halt_in_ds[t];
      end
      if (i_thread_release_instr_dealloc[t]) begin
        f.activated = 1'b0;
      end
      if (i_retire[t] && retire_counts) begin
        f.dirty_flag = 1'b1;
      end
      if (fork_go && i_fork_dst == TW'(t)) begin
        // coprocessor, media and exemption bits are left as they were
        f.thread_fpr_mode = src.thread_fpr_mode;
        f.thread_privilege_mode = src.thread_privilege_mode;
        if (HAS_TLB) begin
          f.thread_space_id = src.thread_space_id;
        end
        f.dirty_flag = 1'b1;
        f.activated = 1'b1;
      end
      state_d.ctx[t] = f;
    end
    state_d.rd_valid = i_sw_rd;
    if (i_sw_rd) begin
      state_d.rd_data = words[i_sw_rd_tc];
    end
  end

  // undefined-at-reset fields are cleared anyway so simulation stays known
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        state_q.ctx[t].thread_coproc_usable <= `TCS_COPROC_RST;
        state_q.ctx[t].thread_media_enable <= `TCS_MEDIA_RST;
        state_q.ctx[t].thread_fpr_mode <= `TCS_FR_RST;
        state_q.ctx[t].run_state <= thread_context_status_pkg::run_state_t'(
          `TCS_RUN_RST);
        state_q.ctx[t].halted_in_delay_slot <= `TCS_DSLOT_RST;
        state_q.ctx[t].dirty_flag <= `TCS_DIRTY_RST;
        state_q.ctx[t].dynamic_alloc_enable <= `TCS_ALLOC_RST;
        state_q.ctx[t].activated <= (t == 0) ? `TCS_ACT_RST_T0
                                             : `TCS_ACT_RST_OTHER;
        state_q.ctx[t].thread_privilege_mode <= `TCS_PRIV_RST;
        state_q.ctx[t].interrupt_exempt <= `TCS_EXEMPT_RST;
        state_q.ctx[t].thread_space_id <= `TCS_ASID_RST;
      end
      state_q.rd_data <= 32'h0000_0000;
      state_q.rd_valid <= 1'b0;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

endmodule : thread_context_status_bank

// file: thread_context_status_checker.sv
// port assertions for the thread context status bank
`timescale 1ns/1ns
module thread_context_status_checker #(
  parameter int NUM_THREADS = 4,
  localparam int TW = (NUM_THREADS > 1) ? $clog2(NUM_THREADS) : 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sw_wr,
  input wire logic i_sw_rd,
  input wire logic i_fork,
  input wire logic [TW-1:0] i_fork_dst,
  input wire logic [TW-1:0] i_cur_tc,
  input wire logic [NUM_THREADS-1:0] i_retire,
  input wire logic [NUM_THREADS-1:0] i_thread_release_instr_dealloc,
  input wire logic i_exception_level_bit,
  input wire logic i_error_level_bit,
  input wire logic i_debug_mode,
  input wire logic [31:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic o_fork_ok,
  input wire logic o_status_media_enable_bit,
  input wire logic [NUM_THREADS-1:0] o_dyn_alloc_en,
  input wire logic [NUM_THREADS-1:0] o_activated,
  input wire logic [NUM_THREADS-1:0] o_media_en,
  input wire logic [NUM_THREADS-1:0] o_dirty
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic inh;
  assign inh = i_exception_level_bit | i_error_level_bit | i_debug_mode;
  a_fork_ok_gate:
    assert property (o_fork_ok == (i_fork && o_dyn_alloc_en[i_fork_dst]))
    else $error("fork acceptance differs from allocation enable");
  a_fork_marks_dst:
    assert property (i_ce && o_fork_ok |=> o_activated[$past(i_fork_dst)]
      && o_dirty[$past(i_fork_dst)])
    else $error("fork did not activate and dirty the target");
  a_reset_levels:
    assert property ($fell(i_rst) |-> o_activated == 1 && o_dirty == 0
      && o_dyn_alloc_en == 0)
    else $error("wrong control levels after reset");
  a_retire_sets_dirty:
    assert property (i_ce && !inh |=>
      (o_dirty & $past(i_retire)) == $past(i_retire))
    else $error("retire did not set dirty");
  a_retire_inhibited:
    assert property (i_ce && inh && !i_fork && !i_sw_wr |=>
      o_dirty == $past(o_dirty))
    else $error("dirty changed while retire was inhibited");
  a_thread_release_instr_clears_act:
    assert property (i_ce && !i_fork |=>
      (o_activated & $past(i_thread_release_instr_dealloc)) == 0)
    else $error("release left thread activated");
  a_read_answers:
    assert property (i_ce && i_sw_rd |=> o_rd_valid)
    else $error("read not answered in one cycle");
  a_reserved_zero:
    assert property (o_rd_valid |-> (o_rd_data & 32'h024f_4300) == 32'h0)
    else $error("reserved bits read nonzero");
  a_media_mirror:
    assert property (o_status_media_enable_bit == o_media_en[i_cur_tc])
    else $error("media enable mirror differs");
endmodule : thread_context_status_checker

bind thread_context_status_bank thread_context_status_checker #(
  .NUM_THREADS(NUM_THREADS)
) u_checker (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_ce(i_ce),
  .i_sw_wr(i_sw_wr),
  .i_sw_rd(i_sw_rd),
  .i_fork(i_fork),
  .i_fork_dst(i_fork_dst),
  .i_cur_tc(i_cur_tc),
  .i_retire(i_retire),
  .i_thread_release_instr_dealloc(i_thread_release_instr_dealloc),
  .i_exception_level_bit(i_exception_level_bit),
  .i_error_level_bit(i_error_level_bit),
  .i_debug_mode(i_debug_mode),
  .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid),
  .o_fork_ok(o_fork_ok),
  .o_status_media_enable_bit(o_status_media_enable_bit),
  .o_dyn_alloc_en(o_dyn_alloc_en),
  .o_activated(o_activated),
  .o_media_en(o_media_en),
  .o_dirty(o_dirty)
);

// file: thread_context_status_defines.svh
// bit positions, reset values and masks of the thread context status word
//
// What this block does
// - One status register per thread context, inside the system coprocessor.
// - Bits 31:28 coprocessor enables, mirrored with shared status; fork keeps them.
// - Bit 27 media-state enable, mirrored with shared status, resets 0, fork keeps.
// - Bit 26 floating-point register mode; fork copies it from forking thread.
// - Read-only bits 24:23 run state, reset 0: run, wait, thread_release_instr, gating.
// - Read-only bit 21 set on halt in delay slot; else cleared on halt/restart write.
// - Bit 20 dirty: set on retire and fork dispatch, reset 0, writable.
// - Retirement does not set dirty under exception level, error level or debug.
// - Bits 19:16 not implemented: writes ignored, reads zero.
// - Bit 15 dynamic allocation enable, reset 0; fork allocates only when set.
// - Bit 13 activated: set by fork, cleared by release; reset 1 only thread 0.
// - Bits 12:11 privilege mode, mirrored both ways with status; fork copies.
// - Bit 10 exempts thread from ordinary interrupts, not debug; reset 0.
// - Bits 7:0 space id mirrored with entry-high; zero without translation buffer.
// - Bits 25, 22, 14, 9:8 reserved: written zero, read zero.
`ifndef THREAD_CONTEXT_STATUS_DEFINES_SVH
`define THREAD_CONTEXT_STATUS_DEFINES_SVH

`define TCS_COPROC_HI 31
`define TCS_COPROC_LO 28
`define TCS_MEDIA_BIT 27
`define TCS_FR_BIT 26
`define TCS_RUN_HI 24
`define TCS_RUN_LO 23
`define TCS_DSLOT_BIT 21
`define TCS_DIRTY_BIT 20
`define TCS_IMPL_HI 19
`define TCS_IMPL_LO 16
`define TCS_ALLOC_BIT 15
`define TCS_ACT_BIT 13
`define TCS_PRIV_HI 12
`define TCS_PRIV_LO 11
`define TCS_EXEMPT_BIT 10
`define TCS_ASID_HI 7
`define TCS_ASID_LO 0

`define TCS_RSVD_MASK 32'h0240_4300

`define TCS_COPROC_RST 4'h0
`define TCS_MEDIA_RST 1'h0
`define TCS_FR_RST 1'h0
`define TCS_RUN_RST 2'h0
`define TCS_DSLOT_RST 1'h0
`define TCS_DIRTY_RST 1'h0
`define TCS_ALLOC_RST 1'h0
`define TCS_ACT_RST_T0 1'h1
`define TCS_ACT_RST_OTHER 1'h0
`define TCS_PRIV_RST 2'h0
`define TCS_EXEMPT_RST 1'h0
`define TCS_ASID_RST 8'h00

`endif

// file: thread_context_status_pkg.sv
// types shared by the thread context status files
package thread_context_status_pkg;

  typedef enum logic [1:0] {
    RUN_ACTIVE,
    RUN_WAIT,
    RUN_THREAD_RELEASE_INSTR,
    RUN_GATING
  } run_state_t;

  typedef struct packed {
    logic [3:0] thread_coproc_usable;
    logic thread_media_enable;
    logic thread_fpr_mode;
    run_state_t run_state;
    logic halted_in_delay_slot;
    logic dirty_flag;
    logic dynamic_alloc_enable;
    logic activated;
    logic [1:0] thread_privilege_mode;
    logic interrupt_exempt;
    logic [7:0] thread_space_id;
  } ctx_fields_t;

endpackage : thread_context_status_pkg

// file: thread_status_word.sv
// packs one thread's fields into the 32-bit status word
`timescale 1ns/1ns
`include "thread_context_status_defines.svh"

module thread_status_word #(
  parameter bit HAS_TLB = 1'b1
) (
  input wire thread_context_status_pkg::ctx_fields_t i_fields,
  output logic [31:0] o_word
);

  always_comb begin
    o_word = 32'h0000_0000;
    o_word[`TCS_COPROC_HI:`TCS_COPROC_LO] = i_fields.thread_coproc_usable;
    o_word[`TCS_MEDIA_BIT] = i_fields.thread_media_enable;
    o_word[`TCS_FR_BIT] = i_fields.thread_fpr_mode;
    o_word[`TCS_RUN_HI:`TCS_RUN_LO] = i_fields.run_state;
    o_word[`TCS_DSLOT_BIT] = i_fields.halted_in_delay_slot;
    o_word[`TCS_DIRTY_BIT] = i_fields.dirty_flag;
    // implementation bits are not built and stay zero
    o_word[`TCS_ALLOC_BIT] = i_fields.dynamic_alloc_enable;
    o_word[`TCS_ACT_BIT] = i_fields.activated;
    o_word[`TCS_PRIV_HI:`TCS_PRIV_LO] = i_fields.thread_privilege_mode;
    o_word[`TCS_EXEMPT_BIT] = i_fields.interrupt_exempt;
    if (HAS_TLB) begin
      o_word[`TCS_ASID_HI:`TCS_ASID_LO] = i_fields.thread_space_id;
    end
    o_word = o_word & ~`TCS_RSVD_MASK;
  end

endmodule : thread_status_word
